/* File: tcbc_params.svh */
// named offsets, field positions, codes and reset values of the trace buffer config block
`ifndef TCBC_PARAMS_SVH
`define TCBC_PARAMS_SVH
`define TCBC_TAP_CTL_C      8'h13
`define TCBC_TAP_CTL_B      8'h1A
`define TCBC_OFS_CTL_C      16'h3010
`define TCBC_OFS_CTL_B      16'h3020
`define TCBC_DRSEG_MIN_REV  8'h06
`define TCBC_B_EN           0
`define TCBC_B_OFC          1
`define TCBC_B_CA           2
`define TCBC_B_CR_LO        8
`define TCBC_B_CR_HI        10
`define TCBC_CR_RESET       3'h3
`define TCBC_C_ASID_HI      31
`define TCBC_C_ASID_LO      30
`define TCBC_C_NDO_HI       29
`define TCBC_C_NDO_LO       28
`define TCBC_C_RW_HI        27
`define TCBC_C_MODE_HI      27
`define TCBC_C_MODE_LO      23
`define TCBC_C_CPUV         22
`define TCBC_C_CPU_SELECT_ID_HI     21
`define TCBC_C_CPU_SELECT_ID_LO     14
`define TCBC_C_TCV          13
`define TCBC_C_THREAD_CTX_NUMBER_HI     12
`define TCBC_C_THREAD_CTX_NUMBER_LO     5
`define TCBC_C_THREAD_CTX_WIDTH_HI    4
`define TCBC_C_THREAD_CTX_WIDTH_LO    2
`define TCBC_C_MTK          1
`define TCBC_C_MTS          0
`define TCBC_STALL_CODE_A   4'h1
`define TCBC_STALL_CODE_B   4'h5
`define TCBC_WORD_ZERO      32'h0000_0000
`endif

/* File: tcbc_pkg.sv */
// types shared by the trace buffer config block
package tcbc_pkg;
	typedef logic [31:0] tcbc_word_t;
	typedef enum logic [1:0] {
		TCBC_IDLE,
		TCBC_RUN,
		TCBC_STOP,
		TCBC_FLUSH
	} tcbc_state_e;
endpackage

/* File: tcbc_core.sv */
// trace control buffer: control registers, stop sequence and trace word delivery
`timescale 1ns/1ps
`include "tcbc_params.svh"

// What this block does
// (R1) cycle_accurate_en set keeps stall info; clear drops it and bit zero of words
// (R2) stall info: stop formats with codes 0001/0101, single-bit formats outside multipipe
// (R3) offchip_target_sel 1 sends trace to probe pins, 0 to on-chip memory
// (R4) target select resets to preset value when both targets exist, else to the one target present; read-only unless both targets exist
// (R5) master enable set/cleared by register write and by start/stop triggers
// (R6) while enabled, trace words are taken and sent to the selected target
// (R7) on disable: emit stop packet last only when a stop trigger disabled it, flush, then ignore further trace
// (R8) clock ratio 000..011 trace 8x..1x faster, 100..111 slower by 2,4,6,8
// (R9) trace input control writable by debug TAP instruction 0x13
// (R10) from revision 6.00 trace input control also at debug segment offset 0x3010
// (R11) trace input control fields drive the core's trace control inputs directly; asid extension goes through one more register
// (R12) asid extension ignores writes, reads zero without TLB MMU or config bit
// (R13) data order width field is read-only preset: 00=4,01=5,10=6,11=8 bits
// (R14) field layout: mode 27:23, cpu valid 22, cpu id 21:14, ctx valid 13, etc.
module tcbc_core #(
	parameter int         TW          = 32,
	parameter int         LW          = 6,
	parameter bit         HAS_OFFCHIP = 1'b1,
	parameter bit         HAS_ONCHIP  = 1'b1,
	parameter bit         OFC_PRESET  = 1'b1,
	parameter bit         HAS_TLB     = 1'b1,
	parameter logic [1:0] DO_WIDTH    = 2'h0,
	parameter logic [7:0] REVISION    = 8'h06,
	parameter logic [TW-1:0] STOP_WORD = '0,
	parameter logic [LW-1:0] STOP_LEN  = 6'h08
) (
	input  wire logic              mclk,
	input  wire logic              rst_b,
	input  wire logic              tclk,
	input  wire logic [7:0]        tap_instr,
	input  wire logic              tap_update,
	input  wire tcbc_pkg::tcbc_word_t tap_wdata,
	output      tcbc_pkg::tcbc_word_t tap_rdata,
	input  wire logic [15:0]       drseg_addr,
	input  wire logic              drseg_wr,
	input  wire logic              drseg_rd,
	input  wire tcbc_pkg::tcbc_word_t drseg_wdata,
	output      tcbc_pkg::tcbc_word_t drseg_rdata,
	input  wire logic              start_trig,
	input  wire logic              stop_trig,
	input  wire logic              asid_ext_config_bit,
	input  wire logic              core_trace_valid,
	input  wire logic [TW-1:0]     core_trace_data,
	input  wire logic [LW-1:0]     core_trace_len,
	input  wire logic              core_fmt_stop,
	input  wire logic [3:0]        core_fmt_code,
	input  wire logic              core_fmt_single,
	input  wire logic              core_fmt_multipipe,
	output logic                   core_trace_ready,
	output logic                   mem_wr_en,
	output logic [TW-1:0]          mem_wdata,
	output logic [LW-1:0]          mem_wlen,
	output logic [TW-1:0]          probe_trace_data_pins,
	output logic [LW-1:0]          probe_trace_len,
	output logic                   probe_trace_valid,
	output logic                   trace_active,
	output logic                   ratio_trace_faster,
	output logic [3:0]             ratio_factor,
	output logic [1:0]             core_asid_ext,
	output logic [4:0]             core_trace_mode,
	output logic                   core_cpu_select_valid,
	output logic [7:0]             core_cpu_select_id,
	output logic                   core_thread_ctx_valid,
	output logic [7:0]             core_thread_ctx_number,
	output logic [2:0]             core_thread_ctx_width,
	output logic                   core_multithread_trace_kind,
	output logic                   core_multithread_trace_select
);
	import tcbc_pkg::*;

	function automatic logic is_stall(input logic stp, input logic [3:0] code,
		input logic single, input logic mpipe);
		is_stall = (stp && (code == `TCBC_STALL_CODE_A || code == `TCBC_STALL_CODE_B))
			|| (single && !mpipe); // [R2]
	endfunction

	// returns {trace faster than core, factor}
	function automatic logic [4:0] ratio_decode(input logic [2:0] cr);
		unique case (cr) // [R8]
			3'h0: ratio_decode = {1'b1, 4'h8};
			3'h1: ratio_decode = {1'b1, 4'h4};
			3'h2: ratio_decode = {1'b1, 4'h2};
			3'h3: ratio_decode = {1'b0, 4'h1};
			3'h4: ratio_decode = {1'b0, 4'h2};
			3'h5: ratio_decode = {1'b0, 4'h4};
			3'h6: ratio_decode = {1'b0, 4'h6};
			3'h7: ratio_decode = {1'b0, 4'h8};
		endcase
	endfunction

	localparam bit OFC_RW = HAS_OFFCHIP && HAS_ONCHIP;
	localparam bit OFC_RST = OFC_RW ? OFC_PRESET : HAS_OFFCHIP;

	// control registers
	logic        en;
	logic        offchip_target_sel;
	logic        ca;
	logic [2:0]  cr;
	logic [1:0]  asid_ext;
	logic [`TCBC_C_RW_HI:0] ctl_c;
	logic        stop_by_trig;
	tcbc_state_e st;

	// register access decode; tap wins over debug segment in the same cycle
	wire         drseg_ok   = REVISION >= `TCBC_DRSEG_MIN_REV; // [R10]
	wire         sel_tap_c  = tap_instr == `TCBC_TAP_CTL_C; // [R9]
	wire         sel_tap_b  = tap_instr == `TCBC_TAP_CTL_B;
	wire         sel_seg_c  = drseg_ok && drseg_addr == `TCBC_OFS_CTL_C; // [R10]
	wire         sel_seg_b  = drseg_ok && drseg_addr == `TCBC_OFS_CTL_B;
	wire         tap_wr_c   = tap_update && sel_tap_c; // [R9]
	wire         tap_wr_b   = tap_update && sel_tap_b;
	wire         seg_wr_c   = drseg_wr && sel_seg_c; // [R10]
	wire         seg_wr_b   = drseg_wr && sel_seg_b;
	wire         wr_b       = tap_wr_b || (seg_wr_b && !tap_update);
	wire         wr_c       = tap_wr_c || (seg_wr_c && !tap_update);
	wire tcbc_word_t wdata  = tap_update ? tap_wdata : drseg_wdata;
	wire         asid_ok    = HAS_TLB && asid_ext_config_bit;

	wire tcbc_word_t rd_b   = {21'h00_0000, cr, 5'h00, ca, offchip_target_sel, en};
	wire tcbc_word_t rd_c   = {asid_ok ? asid_ext : 2'h0, DO_WIDTH, ctl_c}; // [R12] [R13]
	wire tcbc_word_t tap_rd = (tap_instr == `TCBC_TAP_CTL_C) ? rd_c :
		(tap_instr == `TCBC_TAP_CTL_B) ? rd_b : `TCBC_WORD_ZERO;
	wire tcbc_word_t seg_rd = !drseg_ok ? `TCBC_WORD_ZERO :
		(drseg_addr == `TCBC_OFS_CTL_C) ? rd_c :
		(drseg_addr == `TCBC_OFS_CTL_B) ? rd_b : `TCBC_WORD_ZERO;

	// triggers beat a write to the same bit; stop beats start
	wire         next_en    = stop_trig ? 1'b0 : start_trig ? 1'b1 :
		wr_b ? wdata[`TCBC_B_EN] : en; // [R5]
	wire         trig_stop  = stop_trig && en;

	// word slot and link handshake state
	logic            slot_full;
	logic [TW-1:0]   slot_data;
	logic [LW-1:0]   slot_len;
	logic            req;
	logic            busy;
	logic [TW-1:0]   xfer_data;
	logic [LW-1:0]   xfer_len;
	logic            ack_s1;
	logic            ack_s2;
	logic            ack_s3;
	logic            tseen;

	wire             ack_done   = busy && ack_s2 == ack_s3 && ack_s3 == req;
	wire             link_free  = !busy || ack_done;
	wire             drain      = slot_full && (offchip_target_sel ? link_free : 1'b1); // [R3]
	wire             take       = core_trace_valid && core_trace_ready && st == TCBC_RUN; // [R6] [R7]
	wire             stall_in   = is_stall(core_fmt_stop, core_fmt_code, core_fmt_single,
		core_fmt_multipipe);
	wire             keep       = take && (ca || !stall_in); // [R1]
	wire [TW-1:0]    kept_data  = ca ? core_trace_data : {1'b0, core_trace_data[TW-1:1]}; // [R1]
	wire [LW-1:0]    kept_len   = ca ? core_trace_len : core_trace_len - 1'b1; // [R1]
	wire             stop_load  = st == TCBC_STOP && stop_by_trig && !slot_full; // [R7]
	wire             load       = keep || stop_load;
	wire             next_slot_full = (slot_full && !drain) || load;
	wire             flushed    = !slot_full && link_free;

	tcbc_state_e next_st;
	always_comb begin
		next_st = st;
		unique case (st)
			TCBC_IDLE:  if (en) next_st = TCBC_RUN;
			TCBC_RUN:   if (!en) next_st = TCBC_STOP; // [R7]
			TCBC_STOP:  if (!stop_by_trig || !slot_full) next_st = TCBC_FLUSH;
			TCBC_FLUSH: if (flushed && !slot_full) next_st = TCBC_IDLE; // [R7]
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			en    <= 1'b0;
			offchip_target_sel   <= OFC_RST; // [R4]
			ca    <= 1'b0;
			cr    <= `TCBC_CR_RESET;
			st    <= TCBC_IDLE;
			stop_by_trig <= 1'b0;
		end else begin
			en <= next_en; // [R5]
			st <= next_st;
			if (wr_b) begin
				ca <= wdata[`TCBC_B_CA];
				cr <= wdata[`TCBC_B_CR_HI:`TCBC_B_CR_LO];
				if (OFC_RW) offchip_target_sel <= wdata[`TCBC_B_OFC]; // [R4]
			end
			if (trig_stop) stop_by_trig <= 1'b1;
			else if (st == TCBC_FLUSH) stop_by_trig <= 1'b0;
		end
	end

	// asid extension has no defined reset; zero is as good as any
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ctl_c    <= '0;
			asid_ext <= 2'h0;
			core_asid_ext <= 2'h0;
		end else begin
			core_asid_ext <= asid_ok ? asid_ext : 2'h0; // [R11] [R12]
			if (wr_c) begin
				ctl_c <= wdata[`TCBC_C_RW_HI:0]; // [R9] [R10]
				if (asid_ok) asid_ext <= wdata[`TCBC_C_ASID_HI:`TCBC_C_ASID_LO]; // [R12]
			end
		end
	end

	// read data
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			tap_rdata   <= '0;
			drseg_rdata <= '0;
		end else begin
			tap_rdata   <= tap_rd;
			drseg_rdata <= drseg_rd ? seg_rd : `TCBC_WORD_ZERO;
		end
	end

	// status outputs; ratio decoded once here, not at every reader
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			trace_active       <= 1'b0;
			ratio_trace_faster <= 1'b0;
			ratio_factor       <= 4'h1;
		end else begin
			trace_active <= next_st != TCBC_IDLE;
			{ratio_trace_faster, ratio_factor} <= ratio_decode(cr); // [R8]
		end
	end

	// fields drive the core's trace control inputs with no extra staging
	assign core_trace_mode               = ctl_c[`TCBC_C_MODE_HI:`TCBC_C_MODE_LO]; // [R11] [R14]
	assign core_cpu_select_valid         = ctl_c[`TCBC_C_CPUV]; // [R14]
	assign core_cpu_select_id            = ctl_c[`TCBC_C_CPU_SELECT_ID_HI:`TCBC_C_CPU_SELECT_ID_LO]; // [R14]
	assign core_thread_ctx_valid         = ctl_c[`TCBC_C_TCV]; // [R14]
	assign core_thread_ctx_number        = ctl_c[`TCBC_C_THREAD_CTX_NUMBER_HI:`TCBC_C_THREAD_CTX_NUMBER_LO]; // [R14]
	assign core_thread_ctx_width         = ctl_c[`TCBC_C_THREAD_CTX_WIDTH_HI:`TCBC_C_THREAD_CTX_WIDTH_LO]; // [R14]
	assign core_multithread_trace_kind   = ctl_c[`TCBC_C_MTK]; // [R14]
	assign core_multithread_trace_select = ctl_c[`TCBC_C_MTS]; // [R14]

	// one-word slot; ready is registered so it looks at the slot's next state
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			slot_full <= 1'b0;
			slot_data <= '0;
			slot_len  <= '0;
			core_trace_ready <= 1'b0;
		end else begin
			slot_full <= next_slot_full;
			if (keep) begin
				slot_data <= kept_data;
				slot_len  <= kept_len;
			end else if (stop_load) begin
				slot_data <= STOP_WORD; // [R7]
				slot_len  <= STOP_LEN;
			end
			// ready also follows enable, so nothing slips in after a stop
			core_trace_ready <= next_st == TCBC_RUN && next_en && !next_slot_full; // [R6] [R7]
		end
	end

	// on-chip path
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			mem_wr_en <= 1'b0;
			mem_wdata <= '0;
			mem_wlen  <= '0;
		end else begin
			mem_wr_en <= drain && !offchip_target_sel; // [R3] [R6]
			if (drain && !offchip_target_sel) begin
				mem_wdata <= slot_data;
				mem_wlen  <= slot_len;
			end
		end
	end

	// off-chip path: toggle handshake, data held stable while busy
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			req       <= 1'b0;
			busy      <= 1'b0;
			xfer_data <= '0;
			xfer_len  <= '0;
		end else begin
			if (drain && offchip_target_sel) begin
				req       <= !req; // [R3]
				busy      <= 1'b1;
				xfer_data <= slot_data;
				xfer_len  <= slot_len;
			end else if (ack_done) begin
				busy <= 1'b0;
			end
		end
	end

	// acknowledge back from the trace clock; counts once stages two and three agree
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
			ack_s3 <= 1'b0;
		end else begin
			ack_s1 <= tseen;
			ack_s2 <= ack_s1;
			ack_s3 <= ack_s2;
		end
	end

	// link side on the trace clock
	logic req_s1;
	logic req_s2;
	logic req_s3;
	wire  req_new = req_s2 == req_s3 && req_s3 != tseen;

	always_ff @(posedge tclk or negedge rst_b) begin
		if (!rst_b) begin
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
			req_s3 <= 1'b0;
		end else begin
			req_s1 <= req;
			req_s2 <= req_s1;
			req_s3 <= req_s2;
		end
	end

	// one probe pulse per request toggle; word held by the core side while busy
	always_ff @(posedge tclk or negedge rst_b) begin
		if (!rst_b) begin
			tseen  <= 1'b0;
			probe_trace_valid     <= 1'b0;
			probe_trace_data_pins <= '0;
			probe_trace_len       <= '0;
		end else begin
			probe_trace_valid <= req_new; // [R3] [R6]
			if (req_new) begin
				tseen <= req_s3;
				probe_trace_data_pins <= xfer_data;
				probe_trace_len       <= xfer_len;
			end
		end
	end
endmodule // tcbc_core

/* File: tcbc_core_assertions.sv */
// concurrent checks on the trace buffer config block ports
`timescale 1ns/1ps
module tcbc_core_assertions #(
	parameter logic [1:0] DO_WIDTH = 2'h0
) (
	input wire logic                 mclk,
	input wire logic                 rst_b,
	input wire logic [7:0]           tap_instr,
	input wire logic                 tap_update,
	input wire tcbc_pkg::tcbc_word_t tap_wdata,
	input wire logic [15:0]          drseg_addr,
	input wire logic                 drseg_wr,
	input wire logic                 drseg_rd,
	input wire tcbc_pkg::tcbc_word_t drseg_wdata,
	input wire tcbc_pkg::tcbc_word_t drseg_rdata,
	input wire logic                 stop_trig,
	input wire logic                 asid_ext_config_bit,
	input wire logic                 core_trace_valid,
	input wire logic                 core_fmt_stop,
	input wire logic [3:0]           core_fmt_code,
	input wire logic                 core_fmt_single,
	input wire logic                 core_fmt_multipipe,
	input wire logic                 core_trace_ready,
	input wire logic                 mem_wr_en,
	input wire logic                 trace_active,
	input wire logic                 ratio_trace_faster,
	input wire logic [3:0]           ratio_factor,
	input wire logic [4:0]           core_trace_mode,
	input wire logic [7:0]           core_cpu_select_id
);
	import tcbc_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	sequence s_stop_req;
		$rose(stop_trig) && trace_active;
	endsequence
	sequence s_seg_wr;
		drseg_wr && !tap_update;
	endsequence
	a_tap_ctlc_wr: assert property (
		tap_update && tap_instr == 8'h13 |=> core_cpu_select_id == $past(tap_wdata[21:14]))
		else $error("tap write not on core inputs");
	a_seg_ctlc_wr: assert property (
		s_seg_wr and drseg_addr == 16'h3010 |=> core_trace_mode == $past(drseg_wdata[27:23]))
		else $error("segment write not on core inputs");
	a_ratio_decode: assert property (
		s_seg_wr and drseg_addr == 16'h3020 && drseg_wdata[10:8] == 3'h6
		|-> ##[1:2] ratio_factor == 4'h6 && !ratio_trace_faster)
		else $error("ratio one sixth wrong");
	a_ro_fields: assert property (
		drseg_rd && drseg_addr == 16'h3010 && !asid_ext_config_bit
		|=> drseg_rdata[31:28] == {2'h0, DO_WIDTH})
		else $error("read-only fields wrong");
	a_rdata_idle: assert property (
		!drseg_rd |=> drseg_rdata == 32'h0000_0000)
		else $error("read data not zero");
	a_stop_ends: assert property (
		s_stop_req |-> ##[1:100] !trace_active)
		else $error("stop never finished");
	a_idle_quiet: assert property (
		!trace_active [*3] |-> !mem_wr_en)
		else $error("write while idle");
	a_ready_drop: assert property (
		core_trace_valid && core_trace_ready && trace_active
		&& !(core_fmt_stop && (core_fmt_code == 4'h1 || core_fmt_code == 4'h5))
		&& !(core_fmt_single && !core_fmt_multipipe) |=> !core_trace_ready)
		else $error("ready held after take");
endmodule // tcbc_core_assertions

bind tcbc_core tcbc_core_assertions #(.DO_WIDTH(DO_WIDTH)) u_tcbc_chk (.mclk, .rst_b,
	.tap_instr, .tap_update, .tap_wdata, .drseg_addr, .drseg_wr, .drseg_rd, .drseg_wdata,
	.drseg_rdata, .stop_trig, .asid_ext_config_bit, .core_trace_valid, .core_trace_ready,
	.core_fmt_stop, .core_fmt_code, .core_fmt_single, .core_fmt_multipipe,
	.mem_wr_en, .trace_active, .ratio_trace_faster, .ratio_factor, .core_trace_mode,
	.core_cpu_select_id);

/* File: tcbc_probe_model.sv */
// trace probe stand-in: captures words from the trace data pins
`timescale 1ns/1ps
module tcbc_probe_model (
	input  wire logic        tclk,
	input  wire logic        rst_b,
	input  wire logic [31:0] probe_trace_data_pins,
	input  wire logic [5:0]  probe_trace_len,
	input  wire logic        probe_trace_valid,
	output logic      [7:0]  word_cnt,
	output logic      [31:0] last_word,
	output logic      [5:0]  last_len
);
	// never stalls: a real probe samples every pulse
	always_ff @(posedge tclk or negedge rst_b) begin
		if (!rst_b) begin
			word_cnt <= 8'h00;
			last_word <= 32'h0000_0000;
			last_len <= 6'h00;
		end else if (probe_trace_valid) begin
			word_cnt <= word_cnt + 8'h01;
			last_word <= probe_trace_data_pins;
			last_len <= probe_trace_len;
		end
	end
endmodule // tcbc_probe_model

/* File: trace_control_buffer_config_tb.sv */
// self-checking bench for the trace buffer config block
`timescale 1ns/1ps
module trace_control_buffer_config_tb;
	import tcbc_pkg::*;
	logic        mclk, rst_b, tclk, tap_update, drseg_wr, drseg_rd, start_trig, stop_trig;
	logic        asid_ext_config_bit, core_trace_valid, core_fmt_stop, core_fmt_single;
	logic        core_fmt_multipipe, core_trace_ready, mem_wr_en, probe_trace_valid;
	logic        trace_active, ratio_trace_faster, core_cpu_select_valid;
	logic        core_thread_ctx_valid, core_multithread_trace_kind, core_multithread_trace_select;
	logic [7:0]  tap_instr, core_cpu_select_id, core_thread_ctx_number, pcnt;
	logic [15:0] drseg_addr;
	logic [3:0]  core_fmt_code, ratio_factor;
	logic [5:0]  core_trace_len, mem_wlen, probe_trace_len, plen, mlen;
	logic [1:0]  core_asid_ext;
	logic [4:0]  core_trace_mode;
	logic [2:0]  core_thread_ctx_width;
	tcbc_word_t  tap_wdata, tap_rdata, drseg_wdata, drseg_rdata, r;
	logic [31:0] core_trace_data, mem_wdata, probe_trace_data_pins, pword, mlast;
	int          failures = 0, checks_done = 0, mcnt = 0;
	logic [3:0]  rf [8] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h2, 4'h4, 4'h6, 4'h8};
	logic [6:0]  sf [3] = '{7'h44, 7'h54, 7'h02};
	localparam tcbc_word_t P = 32'hC5A3_96E9;
	tcbc_core uut (.mclk, .rst_b, .tclk, .tap_instr, .tap_update, .tap_wdata, .tap_rdata,
		.drseg_addr, .drseg_wr, .drseg_rd, .drseg_wdata, .drseg_rdata, .start_trig,
		.stop_trig, .asid_ext_config_bit, .core_trace_valid, .core_trace_data,
		.core_trace_len, .core_fmt_stop, .core_fmt_code, .core_fmt_single, .core_fmt_multipipe,
		.core_trace_ready, .mem_wr_en, .mem_wdata, .mem_wlen, .probe_trace_data_pins,
		.probe_trace_len, .probe_trace_valid, .trace_active, .ratio_trace_faster,
		.ratio_factor, .core_asid_ext, .core_trace_mode, .core_cpu_select_valid,
		.core_cpu_select_id, .core_thread_ctx_valid, .core_thread_ctx_number,
		.core_thread_ctx_width, .core_multithread_trace_kind, .core_multithread_trace_select);
	tcbc_probe_model u_probe (.tclk, .rst_b, .probe_trace_data_pins, .probe_trace_len,
		.probe_trace_valid, .word_cnt(pcnt), .last_word(pword), .last_len(plen));
	initial mclk = 1'b0;
	always #20 mclk = ~mclk;
	initial begin
		tclk = 1'b0;
		#13;
		forever #80 tclk = ~tclk;
	end
	always @(posedge mclk) if (mem_wr_en === 1'b1) begin
		mcnt <= mcnt + 1;
		mlast <= mem_wdata;
		mlen <= mem_wlen;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic seg_wr(input logic [15:0] a, input tcbc_word_t d);
		@(negedge mclk);
		{drseg_addr, drseg_wdata, drseg_wr} = {a, d, 1'b1};
		@(negedge mclk);
		drseg_wr = 1'b0;
	endtask
	task automatic seg_rd(input logic [15:0] a);
		@(negedge mclk);
		{drseg_addr, drseg_rd} = {a, 1'b1};
		@(negedge mclk);
		r = drseg_rdata;
		drseg_rd = 1'b0;
	endtask
	task automatic ck_ctlc(input tcbc_word_t p);
		@(negedge mclk);
		chk({core_trace_mode, core_cpu_select_valid, core_cpu_select_id, core_thread_ctx_valid,
			core_thread_ctx_number, core_thread_ctx_width, core_multithread_trace_kind,
			core_multithread_trace_select}, {4'h0, p[27:0]});
	endtask
	// format bits: stop, code, single, multipipe
	task automatic send(input logic [31:0] d, input logic [6:0] f);
		@(negedge mclk);
		{core_fmt_stop, core_fmt_code, core_fmt_single, core_fmt_multipipe} = f;
		{core_trace_data, core_trace_len, core_trace_valid} = {d, 6'h08, 1'b1};
		for (int i = 0; i < 20 && core_trace_ready !== 1'b1; i++) @(negedge mclk);
		@(negedge mclk);
		core_trace_valid = 1'b0;
	endtask
	task automatic wait_cnt(input bit probe, input int n);
		for (int i = 0; i < 100 && (probe ? int'(pcnt) : mcnt) != n; i++) @(negedge mclk);
	endtask
	task automatic print_verdict();
		if (failures == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#400_000;
		failures++;
		print_verdict();
	end
	initial begin
		{rst_b, tap_update, drseg_wr, drseg_rd, start_trig, stop_trig} = '0;
		{asid_ext_config_bit, core_trace_valid, core_fmt_stop, core_fmt_single} = '0;
		{core_fmt_multipipe, tap_instr, drseg_addr, core_fmt_code, core_trace_len} = '0;
		{tap_wdata, drseg_wdata, core_trace_data} = '0;
		repeat (3) @(negedge mclk);
		rst_b = 1'b1;
		seg_rd(16'h3020);
		chk(r, 32'h0000_0302);
		seg_rd(16'h3000);
		chk(r, 32'h0000_0000);
		for (int i = 0; i < 8; i++) begin
			seg_wr(16'h3020, 32'(i) << 8);
			repeat (2) @(negedge mclk);
			chk(32'(ratio_factor), 32'(rf[i]));
			chk(32'(ratio_trace_faster), 32'(i < 3));
		end
		tap_instr = 8'h13;
		@(negedge mclk) tap_update = 1'b1;
		tap_wdata = P;
		@(negedge mclk) tap_update = 1'b0;
		ck_ctlc(P);
		chk(tap_rdata, {4'h0, P[27:0]});
		seg_wr(16'h3010, ~P);
		ck_ctlc(~P);
		asid_ext_config_bit = 1'b1;
		seg_wr(16'h3010, P);
		ck_ctlc(P);
		chk(32'(core_asid_ext), 32'(P[31:30]));
		asid_ext_config_bit = 1'b0;
		seg_rd(16'h3010);
		chk(r, {4'h0, P[27:0]});
		seg_wr(16'h3020, 32'h0000_0305);
		send(32'h1234_5679, 7'h44);
		wait_cnt(1'b0, 1);
		chk(mlast, 32'h1234_5679);
		chk(32'(mlen), 32'h0000_0008);
		seg_wr(16'h3020, 32'h0000_0301);
		foreach (sf[i]) send(32'hFFFF_FFFF, sf[i]);
		send(32'h0000_00F3, 7'h03);
		wait_cnt(1'b0, 2);
		chk(mlast, 32'h0000_0079);
		chk(32'(mlen), 32'h0000_0007);
		chk(32'(mcnt), 32'h0000_0002);
		seg_wr(16'h3020, 32'h0000_0307);
		send(32'hA5A5_0F0F, 7'h00);
		wait_cnt(1'b1, 1);
		chk(pword, 32'hA5A5_0F0F);
		@(negedge mclk) stop_trig = 1'b1;
		@(negedge mclk) stop_trig = 1'b0;
		wait_cnt(1'b1, 2);
		chk(32'(plen), 32'h0000_0008);
		chk(pword, 32'h0000_0000);
		for (int i = 0; i < 100 && trace_active !== 1'b0; i++) @(negedge mclk);
		chk(32'(trace_active), 32'h0000_0000);
		seg_rd(16'h3020);
		chk(r, 32'h0000_0306);
		send(32'h5A5A_F0F0, 7'h00);
		repeat (30) @(negedge mclk);
		chk(32'(pcnt), 32'h0000_0002);
		chk(32'(mcnt), 32'h0000_0002);
		@(negedge mclk) start_trig = 1'b1;
		@(negedge mclk) start_trig = 1'b0;
		seg_rd(16'h3020);
		chk(r, 32'h0000_0307);
		print_verdict();
	end
endmodule // trace_control_buffer_config_tb
